// [inc/fpes_pkg.sv]
package fpes_pkg;

  // Widths of the flash bus.
  localparam int AW = 18;
  localparam int DW = 16;

  // Timing, in nanoseconds and derived clock counts.
  localparam int CLK_NS        = 40;
  localparam int T_WP_NS       = 50;
  localparam int T_ACC_NS      = 120;
  localparam int T_SECT_WIN_NS = 80000;
  localparam int SYNC_LAT      = 5;
  localparam logic [3:0] WP_CYC   = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] RD_CYC   = 4'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_LAT);
  localparam logic [3:0] TMR_ONE  = 4'h1;
  localparam logic [11:0] WIN_CYC    = 12'(T_SECT_WIN_NS / CLK_NS);
  localparam logic [11:0] ADD_MARGIN = 12'h020;
  localparam logic [11:0] WIN_MAX    = 12'hFFF;

  // Register byte offsets.
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_ADDR = 5'h04;
  localparam logic [4:0] REG_DATA = 5'h08;
  localparam logic [4:0] REG_STAT = 5'h0C;

  // Control fields.
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_OP_MSB = 2;
  localparam int CTRL_HWRST  = 8;

  // Status fields.
  localparam int ST_BUSY   = 0;
  localparam int ST_DONE   = 1;
  localparam int ST_FAIL   = 2;
  localparam int ST_LATE   = 3;
  localparam int ST_READY  = 4;
  localparam int ST_RD_LSB = 16;

  // Operation codes written to the control register.
  localparam logic [2:0] OP_NONE  = 3'h0;
  localparam logic [2:0] OP_PROG  = 3'h1;
  localparam logic [2:0] OP_CHIP  = 3'h2;
  localparam logic [2:0] OP_SECT  = 3'h3;
  localparam logic [2:0] OP_ADD   = 3'h4;
  localparam logic [2:0] OP_RESET = 3'h5;
  localparam logic [2:0] OP_READ  = 3'h6;

  // Command cycles seen by the flash.
  localparam logic [AW-1:0] UNLK_ADDR1 = 18'h00555;
  localparam logic [AW-1:0] UNLK_ADDR2 = 18'h002AA;
  localparam logic [DW-1:0] CMD_UNLK1  = 16'h00AA;
  localparam logic [DW-1:0] CMD_UNLK2  = 16'h0055;
  localparam logic [DW-1:0] CMD_PROG   = 16'h00A0;
  localparam logic [DW-1:0] CMD_ESETUP = 16'h0080;
  localparam logic [DW-1:0] CMD_CHIP   = 16'h0010;
  localparam logic [DW-1:0] CMD_SECT   = 16'h0030;
  localparam logic [DW-1:0] CMD_RESET  = 16'h00F0;
  localparam logic [2:0] LEN_PROG  = 3'h4;
  localparam logic [2:0] LEN_ERASE = 3'h6;
  localparam logic [2:0] LEN_ONE   = 3'h1;
  localparam logic [2:0] SECT_LAST = 3'h5;

  // Status bit positions on the data pins.
  localparam int DQ_POLL = 7;
  localparam int DQ_TOUT = 5;

  typedef enum logic [2:0] {S_IDLE, S_WSET, S_WLOW, S_WHOLD, S_RLOW, S_RHOLD} fpes_state_t;

endpackage

// [rtl/fpes_sync3.sv]
`timescale 1ns/1ps
module fpes_sync3 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Asynchronous input and its settled copy
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] q_q;

  // A change is taken only once two later stages agree, so a one-cycle glitch never lands.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q_q  <= '0;
    end
    else
    begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        q_q <= s3_q;
    end
  end

  assign q = q_q;

endmodule

// [rtl/fpes_host.sv]
`timescale 1ns/1ps
// Function
// - A program operation is exactly four writes and programs one location.
// - Program writes: two unlock cycles, program setup, then address with data.
// - Chip erase: two unlocks, setup, two unlocks, chip erase command.
// - Sector erase ends with command 30H written to an address in the sector.
// - Extra sectors must be written within 80 us of the previous write.
// - While polling sector erase, read only inside the sectors being erased.
module fpes_host (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RESETN,
  // Avalon-MM slave
  input  wire logic [4:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // Flash pins
  output logic      [17:0] FL_ADDR,
  output logic      [15:0] FL_DQ_O,
  output logic             FL_DQ_OE,
  input  wire logic [15:0] FL_DQ_I,
  output logic             FL_CE_N,
  output logic             FL_WE_N,
  output logic             FL_OE_N,
  output logic             FL_RESET_N,
  input  wire logic        FL_READY_BUSY_OUT
);

  fpes_pkg::fpes_state_t st_q;
  logic                  wait_q;
  logic [31:0]           rdata_q;
  logic [17:0]           reg_addr_q;
  logic [15:0]           reg_data_q;
  logic                  hwrst_q;
  logic [3:0]            tmr_q;
  logic [2:0]            step_q;
  logic [2:0]            op_q;
  logic [17:0]           op_addr_q;
  logic [15:0]           data_lat_q;
  logic [15:0]           rd_data_q;
  logic                  poll_q;
  logic                  t5_q;
  logic                  fail_pend_q;
  logic                  add_pend_q;
  logic                  done_q;
  logic                  fail_q;
  logic                  late_q;
  logic [11:0]           win_q;
  logic [3:0]            we_cnt_q;
  logic [17:0]           fl_addr_q;
  logic [15:0]           fl_dq_q;
  logic                  fl_oe_q;
  logic                  ce_n_q;
  logic                  we_n_q;
  logic                  oe_n_q;
  logic                  rst_n_q;
  logic [15:0]           dq_s;
  logic                  ready_s;
  logic                  wr_acc;
  logic                  ctrl_wr;
  logic [2:0]            cmd_op;
  logic                  start;
  logic                  busy;
  logic                  exp7;
  logic [31:0]           addr_m;
  logic [31:0]           data_m;
  logic [31:0]           stat;
  logic [33:0]           seq_w;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  // One command cycle as {address, data} for an operation and step.
  function automatic logic [33:0] seq_word(input logic [2:0] op, input logic [2:0] step,
                                           input logic [17:0] a, input logic [15:0] d);
    logic [33:0] r;
    r = {fpes_pkg::UNLK_ADDR1, fpes_pkg::CMD_RESET};
    case (step)
      3'h0:    r = {fpes_pkg::UNLK_ADDR1, fpes_pkg::CMD_UNLK1};
      3'h1:    r = {fpes_pkg::UNLK_ADDR2, fpes_pkg::CMD_UNLK2};
      3'h2:    r = {fpes_pkg::UNLK_ADDR1,
                    (op == fpes_pkg::OP_PROG) ? fpes_pkg::CMD_PROG : fpes_pkg::CMD_ESETUP};
      3'h3:    r = (op == fpes_pkg::OP_PROG) ? {a, d} :
                   {fpes_pkg::UNLK_ADDR1, fpes_pkg::CMD_UNLK1};
      3'h4:    r = {fpes_pkg::UNLK_ADDR2, fpes_pkg::CMD_UNLK2};
      3'h5:    r = (op == fpes_pkg::OP_CHIP) ? {fpes_pkg::UNLK_ADDR1, fpes_pkg::CMD_CHIP} :
                   {a, fpes_pkg::CMD_SECT};
      default: r = {fpes_pkg::UNLK_ADDR1, fpes_pkg::CMD_RESET};
    endcase
    if (op == fpes_pkg::OP_RESET)
      r = {fpes_pkg::UNLK_ADDR1, fpes_pkg::CMD_RESET};
    return r;
  endfunction

  function automatic logic [2:0] seq_len(input logic [2:0] op);
    case (op)
      fpes_pkg::OP_PROG: return fpes_pkg::LEN_PROG;
      fpes_pkg::OP_CHIP: return fpes_pkg::LEN_ERASE;
      fpes_pkg::OP_SECT: return fpes_pkg::LEN_ERASE;
      default:           return fpes_pkg::LEN_ONE;
    endcase
  endfunction

  fpes_sync3 #(.W(16)) u_dq_sync (.clk(CLK), .rst_n(RESETN), .d(FL_DQ_I), .q(dq_s));
  fpes_sync3 #(.W(1)) u_rb_sync (.clk(CLK), .rst_n(RESETN), .d(FL_READY_BUSY_OUT), .q(ready_s));

  ////////////////////////////////////////////////////////////////////////////////////////////
  assign wr_acc  = AVS_WRITE && !wait_q;
  assign ctrl_wr = wr_acc && AVS_ADDRESS == fpes_pkg::REG_CTRL && AVS_BYTEENABLE[0];
  assign cmd_op  = AVS_WRITEDATA[fpes_pkg::CTRL_OP_MSB:fpes_pkg::CTRL_OP_LSB];
  assign busy    = st_q != fpes_pkg::S_IDLE;
  assign addr_m  = be_merge({14'h0000, reg_addr_q}, AVS_WRITEDATA, AVS_BYTEENABLE);
  assign data_m  = be_merge({16'h0000, reg_data_q}, AVS_WRITEDATA, AVS_BYTEENABLE);
  assign seq_w   = seq_word(op_q, step_q, op_addr_q, data_lat_q);
  assign exp7    = (op_q == fpes_pkg::OP_PROG) ? data_lat_q[fpes_pkg::DQ_POLL] : 1'b1;
  // Busy refuses commands
  // New work is refused while busy, since the flash itself would drop it.
  assign start   = ctrl_wr && !busy && !hwrst_q &&
                   (cmd_op == fpes_pkg::OP_PROG || cmd_op == fpes_pkg::OP_CHIP ||
                    cmd_op == fpes_pkg::OP_SECT || cmd_op == fpes_pkg::OP_RESET ||
                    cmd_op == fpes_pkg::OP_READ);

  always_comb
  begin
    stat = '0;
    stat[fpes_pkg::ST_BUSY]  = busy;
    stat[fpes_pkg::ST_DONE]  = done_q;
    stat[fpes_pkg::ST_FAIL]  = fail_q;
    stat[fpes_pkg::ST_LATE]  = late_q;
    stat[fpes_pkg::ST_READY] = ready_s;
    stat[fpes_pkg::ST_RD_LSB +: 16] = rd_data_q;
  end

  // Every access answers one cycle after it is seen; unmapped reads return zero.
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      wait_q  <= 1'b1;
      rdata_q <= '0;
    end
    else
    begin
      wait_q <= !((AVS_READ || AVS_WRITE) && wait_q);
      if (AVS_READ && wait_q)
        case (AVS_ADDRESS)
          fpes_pkg::REG_ADDR: rdata_q <= {14'h0000, reg_addr_q};
          fpes_pkg::REG_DATA: rdata_q <= {16'h0000, reg_data_q};
          fpes_pkg::REG_STAT: rdata_q <= stat;
          default:            rdata_q <= '0;
        endcase
    end
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      reg_addr_q <= '0;
      reg_data_q <= '0;
      hwrst_q    <= 1'b0;
    end
    else if (wr_acc)
    begin
      if (AVS_ADDRESS == fpes_pkg::REG_ADDR)
        reg_addr_q <= addr_m[17:0];
      if (AVS_ADDRESS == fpes_pkg::REG_DATA)
        reg_data_q <= data_m[15:0];
      if (AVS_ADDRESS == fpes_pkg::REG_CTRL && AVS_BYTEENABLE[1])
        hwrst_q <= AVS_WRITEDATA[fpes_pkg::CTRL_HWRST];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      st_q        <= fpes_pkg::S_IDLE;
      tmr_q       <= '0;
      step_q      <= '0;
      op_q        <= fpes_pkg::OP_NONE;
      op_addr_q   <= '0;
      data_lat_q  <= '0;
      rd_data_q   <= '0;
      poll_q      <= 1'b0;
      t5_q        <= 1'b0;
      fail_pend_q <= 1'b0;
      add_pend_q  <= 1'b0;
      done_q      <= 1'b0;
      fail_q      <= 1'b0;
      late_q      <= 1'b0;
    end
    else if (hwrst_q)
    begin
      if (busy)
        fail_q <= 1'b1;
      st_q        <= fpes_pkg::S_IDLE;
      poll_q      <= 1'b0;
      add_pend_q  <= 1'b0;
      fail_pend_q <= 1'b0;
    end
    else
    begin
      if (busy && tmr_q != '0)
        tmr_q <= tmr_q - fpes_pkg::TMR_ONE;
      else
        case (st_q)
          fpes_pkg::S_IDLE:
            if (start)
            begin
              op_q        <= cmd_op;
              op_addr_q   <= reg_addr_q;
              data_lat_q  <= reg_data_q;
              step_q      <= '0;
              done_q      <= 1'b0;
              fail_q      <= 1'b0;
              late_q      <= 1'b0;
              t5_q        <= 1'b0;
              poll_q      <= 1'b0;
              fail_pend_q <= 1'b0;
              add_pend_q  <= 1'b0;
              st_q  <= (cmd_op == fpes_pkg::OP_READ) ? fpes_pkg::S_RLOW : fpes_pkg::S_WSET;
              tmr_q <= (cmd_op == fpes_pkg::OP_READ) ? fpes_pkg::RD_CYC : fpes_pkg::WP_CYC;
            end
          fpes_pkg::S_WSET:
          begin
            st_q  <= fpes_pkg::S_WLOW;
            tmr_q <= fpes_pkg::WP_CYC;
          end
          fpes_pkg::S_WLOW:
          begin
            st_q  <= fpes_pkg::S_WHOLD;
            tmr_q <= fpes_pkg::WP_CYC;
          end
          fpes_pkg::S_WHOLD:
            if (step_q + 3'h1 < seq_len(op_q))
            begin
              step_q <= step_q + 3'h1;
              st_q   <= fpes_pkg::S_WSET;
              tmr_q  <= fpes_pkg::WP_CYC;
            end
            else if (op_q != fpes_pkg::OP_RESET)
            begin
              poll_q <= 1'b1;
              st_q   <= fpes_pkg::S_RLOW;
              tmr_q  <= fpes_pkg::RD_CYC;
            end
            else
            begin
              st_q   <= fpes_pkg::S_IDLE;
              done_q <= !fail_pend_q;
              fail_q <= fail_pend_q;
            end
          fpes_pkg::S_RLOW:
          begin
            rd_data_q <= dq_s;
            st_q      <= fpes_pkg::S_RHOLD;
            tmr_q     <= fpes_pkg::WP_CYC;
          end
          fpes_pkg::S_RHOLD:
            if (!poll_q)
            begin
              st_q   <= fpes_pkg::S_IDLE;
              done_q <= 1'b1;
            end
            else if (add_pend_q)
            begin
              add_pend_q <= 1'b0;
              if (win_q < fpes_pkg::WIN_CYC - fpes_pkg::ADD_MARGIN)
              begin
                op_addr_q <= reg_addr_q;
                step_q    <= fpes_pkg::SECT_LAST;
                st_q      <= fpes_pkg::S_WSET;
                tmr_q     <= fpes_pkg::WP_CYC;
              end
              else
              begin
                late_q <= 1'b1;
                st_q   <= fpes_pkg::S_RLOW;
                tmr_q  <= fpes_pkg::RD_CYC;
              end
            end
            else if (rd_data_q[fpes_pkg::DQ_POLL] == exp7)
            begin
              st_q   <= fpes_pkg::S_IDLE;
              done_q <= 1'b1;
              poll_q <= 1'b0;
            end
            else if (t5_q)
            begin
              fail_pend_q <= 1'b1;
              op_q        <= fpes_pkg::OP_RESET;
              step_q      <= '0;
              poll_q      <= 1'b0;
              st_q        <= fpes_pkg::S_WSET;
              tmr_q       <= fpes_pkg::WP_CYC;
            end
            else
            begin
              t5_q  <= rd_data_q[fpes_pkg::DQ_TOUT];
              st_q  <= fpes_pkg::S_RLOW;
              tmr_q <= fpes_pkg::RD_CYC;
            end
          default: st_q <= fpes_pkg::S_IDLE;
        endcase
      // Only sector adds
      // Placed last so that a new request survives the service of an older one.
      if (ctrl_wr && cmd_op == fpes_pkg::OP_ADD && poll_q && op_q == fpes_pkg::OP_SECT)
        add_pend_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      win_q <= '0;
    else if (st_q == fpes_pkg::S_WHOLD && op_q == fpes_pkg::OP_SECT)
      win_q <= '0;
    else if (win_q != fpes_pkg::WIN_MAX)
      win_q <= win_q + 12'h001;
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      we_cnt_q <= '0;
    else if (start)
      we_cnt_q <= '0;
    else if (st_q == fpes_pkg::S_WLOW && tmr_q == '0)
      we_cnt_q <= we_cnt_q + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Write strobes inside address; read strobes fall with it
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      fl_addr_q <= '0;
      fl_dq_q   <= '0;
      fl_oe_q   <= 1'b0;
      ce_n_q    <= 1'b1;
      we_n_q    <= 1'b1;
      oe_n_q    <= 1'b1;
      rst_n_q   <= 1'b0;
    end
    else
    begin
      rst_n_q <= !hwrst_q;
      case (st_q)
        fpes_pkg::S_WSET:
        begin
          fl_addr_q <= seq_w[33:16];
          fl_dq_q   <= seq_w[15:0];
          fl_oe_q   <= 1'b1;
          ce_n_q    <= 1'b1;
          we_n_q    <= 1'b1;
          oe_n_q    <= 1'b1;
        end
        fpes_pkg::S_WLOW:
        begin
          ce_n_q <= 1'b0;
          we_n_q <= 1'b0;
        end
        fpes_pkg::S_WHOLD:
        begin
          ce_n_q <= 1'b1;
          we_n_q <= 1'b1;
        end
        fpes_pkg::S_RLOW:
        begin
          fl_addr_q <= op_addr_q;
          fl_oe_q   <= 1'b0;
          ce_n_q    <= 1'b0;
          oe_n_q    <= 1'b0;
        end
        default:
        begin
          fl_oe_q <= 1'b0;
          ce_n_q  <= 1'b1;
          we_n_q  <= 1'b1;
          oe_n_q  <= 1'b1;
        end
      endcase
    end
  end

  assign AVS_READDATA    = rdata_q;
  assign AVS_WAITREQUEST = wait_q;
  assign FL_ADDR         = fl_addr_q;
  assign FL_DQ_O         = fl_dq_q;
  assign FL_DQ_OE        = fl_oe_q;
  assign FL_CE_N         = ce_n_q;
  assign FL_WE_N         = we_n_q;
  assign FL_OE_N         = oe_n_q;
  assign FL_RESET_N      = rst_n_q;

  ////////////////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  a_prog_four_writes: assert property ($rose(poll_q) && op_q == fpes_pkg::OP_PROG |-> we_cnt_q == 4'h4) else $error("program not four writes");
  a_unlock_first: assert property ($fell(FL_WE_N) && step_q == 3'h0 && op_q != fpes_pkg::OP_RESET |-> FL_ADDR == fpes_pkg::UNLK_ADDR1 && FL_DQ_O == fpes_pkg::CMD_UNLK1) else $error("first write not unlock");
  a_prog_setup: assert property ($fell(FL_WE_N) && op_q == fpes_pkg::OP_PROG && step_q == 3'h2 |-> FL_DQ_O == fpes_pkg::CMD_PROG) else $error("program setup missing");
  a_strobe_hold: assert property ($rose(FL_WE_N) |-> $stable(FL_ADDR) && $stable(FL_DQ_O) && FL_DQ_OE && $past(FL_DQ_OE)) else $error("address or data moved at strobe rise");
  a_chip_six_writes: assert property ($rose(poll_q) && op_q == fpes_pkg::OP_CHIP |-> we_cnt_q == 4'h6) else $error("chip erase not six writes");
  a_sector_cmd: assert property ($fell(FL_WE_N) && op_q == fpes_pkg::OP_SECT && step_q == 3'h5 |-> FL_DQ_O == fpes_pkg::CMD_SECT && FL_ADDR == op_addr_q) else $error("bad sector command");
  a_add_in_window: assert property ($fell(FL_WE_N) && op_q == fpes_pkg::OP_SECT && step_q == 3'h5 |-> win_q < fpes_pkg::WIN_CYC) else $error("sector write after window");
  a_poll_address: assert property ($fell(FL_OE_N) && poll_q |-> FL_ADDR == op_addr_q) else $error("poll outside target");
  a_fail_reset_cmd: assert property ($rose(fail_pend_q) |-> ##[1:8] ($fell(FL_WE_N) && FL_DQ_O == fpes_pkg::CMD_RESET)) else $error("no reset after timeout");
  a_done_true_data: assert property ($rose(done_q) && op_q == fpes_pkg::OP_PROG |-> rd_data_q[fpes_pkg::DQ_POLL] == data_lat_q[fpes_pkg::DQ_POLL]) else $error("done without true data");

  c_prog_done: cover property ($rose(done_q) && op_q == fpes_pkg::OP_PROG);
  c_chip_done: cover property ($rose(done_q) && op_q == fpes_pkg::OP_CHIP);
  c_sector_add: cover property ($fell(FL_WE_N) && poll_q && op_q == fpes_pkg::OP_SECT);
  c_timeout_fail: cover property ($rose(fail_q) && op_q == fpes_pkg::OP_RESET);

endmodule

// [verification/fpes_flash_model.sv]
`timescale 1ns/1ps
module fpes_flash_model (
  // Flash bus
  input  wire logic [17:0] addr,
  input  wire logic [15:0] dq_o,
  output logic      [15:0] dq_i,
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  // Reset and ready
  input  wire logic        reset_n,
  output logic             ready_busy_out
);
  logic [15:0] mem [logic [17:0]];
  logic [17:0] a_q;
  logic [15:0] pd, d_last;
  logic [19:0] k;
  logic [7:0]  sect;
  int          cyc;
  logic        busy, acc, ers, tout, tog;
  realtime     t_last;
  wire         ws = ce_n | we_n;
  initial
  begin
    {busy, acc, ers, tout, tog, cyc, sect, pd, d_last} = '0;
    ready_busy_out = 1'b1;
  end
  function automatic logic [15:0] rd(input logic [17:0] a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction
  // Self-timed busy period, cut short by hardware reset.
  task automatic hold(input int n);
    busy = 1'b1;
    ready_busy_out = 1'b0;
    for (int i = 0; i < n && reset_n; i++) #40;
    busy = 1'b0;
    ready_busy_out = 1'b1;
  endtask
  // Programming only clears bits; a 1 over a 0 fails.
  task automatic prog(input logic [17:0] a, input logic [15:0] d);
    pd = d;
    hold(100);
    if (reset_n) tout = |(d & ~rd(a));
    if (reset_n) mem[a] = rd(a) & d;
  endtask
  task automatic erase(input logic chip);
    ers = 1'b1;
    ready_busy_out = 1'b0;
    while (acc && $realtime - t_last < 80000.0) #40;
    if (chip || acc)
    begin
      acc = 1'b0;
      hold(100);
      foreach (mem[j]) if (reset_n && (chip || sect[j[17:15]])) mem[j] = 16'hFFFF;
    end
    {ers, sect} = '0;
    ready_busy_out = 1'b1;
  endtask
  //////////////////////////////////////////////////////////////////
  // Address on the later fall; each fall, and each rise taken as a write, restarts the window.
  always @(negedge ws)
  begin
    a_q = addr;
    t_last = $realtime;
  end
  // Data on the earlier rise; ignored while busy.
  always @(posedge ws)
    if (reset_n && !busy)
    begin
      t_last = $realtime;
      k = {a_q[11:0], dq_o[7:0]};
      if (dq_o[7:0] == 8'hF0) {cyc, acc, tout} = '0;
      else if (!tout && acc && dq_o[7:0] == 8'h30) sect[a_q[17:15]] = 1'b1;
      else if (!tout && acc) acc = 1'b0;
      // Command cycles; a stray write drops them.
      else if (!tout)
        case (cyc)
          0, 3: cyc = (k == 20'h555AA) ? cyc + 1 : 0;
          1, 4: cyc = (k == 20'h2AA55) ? cyc + 1 : 0;
          2: cyc = (k == 20'h555A0) ? 6 : (k == 20'h55580) ? 3 : 0;
          5:
          begin
            cyc = 0;
            if (k == 20'h55510) fork erase(1'b1); join_none
            else if (dq_o[7:0] == 8'h30)
            begin
              sect[a_q[17:15]] = 1'b1;
              acc = 1'b1;
              fork erase(1'b0); join_none
            end
          end
          default:
          begin
            cyc = 0;
            fork prog(a_q, dq_o); join_none
          end
        endcase
    end
  // Hardware reset returns to read mode.
  always @(negedge reset_n) {cyc, acc, tout} = '0;
  always @(negedge oe_n) tog = ~tog;
  // Status while busy or failed, true data after; deselected, the bus drives the inverse of the last read.
  always @*
    if (ce_n || oe_n) dq_i = ~d_last;
    else if (busy || acc || tout)
    begin
      dq_i = {8'h00, ~ers & ~pd[7], tog, tout, 5'h00};
      d_last = dq_i;
    end
    else
    begin
      dq_i = rd(addr);
      d_last = dq_i;
    end
endmodule

// [verification/flash_program_erase_sequencer_tb.sv]
`timescale 1ns/1ps
module flash_program_erase_sequencer_tb;
  logic        clk, rst_n, av_rd, av_wr, dq_oe, ce_n, we_n, oe_n, fl_rst_n, ready_busy_out, av_wait;
  logic [4:0]  av_a;
  logic [31:0] av_wd, av_rdata, s;
  logic [17:0] fl_a;
  logic [15:0] dq_o, dq_m;
  int          err_count, tests_run, ticks;
  fpes_host u_fpes_host (.CLK(clk), .RESETN(rst_n), .AVS_ADDRESS(av_a), .AVS_READ(av_rd),
    .AVS_WRITE(av_wr), .AVS_WRITEDATA(av_wd), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(av_rdata),
    .AVS_WAITREQUEST(av_wait), .FL_ADDR(fl_a), .FL_DQ_O(dq_o), .FL_DQ_OE(dq_oe),
    .FL_DQ_I(dq_oe ? dq_o : dq_m), .FL_CE_N(ce_n), .FL_WE_N(we_n), .FL_OE_N(oe_n),
    .FL_RESET_N(fl_rst_n), .FL_READY_BUSY_OUT(ready_busy_out));
  fpes_flash_model u_fpes_flash_model (.addr(fl_a), .dq_o(dq_o), .dq_i(dq_m), .ce_n(ce_n),
    .we_n(we_n), .oe_n(oe_n), .reset_n(fl_rst_n), .ready_busy_out(ready_busy_out));
  task automatic report_and_stop;
    $display("compares %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) err_count++;
    if (got !== exp) $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
  endtask
  //////////////////////////////////////////////////////////////////
  // One request is held until waitrequest is seen low at a rising edge.
  task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    av_a <= a;
    av_wd <= d;
    av_wr <= w;
    av_rd <= ~w;
    do @(posedge clk); while (av_wait !== 1'b0);
    s = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
  endtask
  task automatic go(input logic [2:0] c, input logic [17:0] a, input logic [15:0] d);
    bus(fpes_pkg::REG_ADDR, 1'b1, 32'(a));
    bus(fpes_pkg::REG_DATA, 1'b1, 32'(d));
    bus(fpes_pkg::REG_CTRL, 1'b1, 32'(c));
  endtask
  task automatic fin;
    do bus(fpes_pkg::REG_STAT, 1'b0, '0); while (s[0] !== 1'b0 || s[2:1] === 2'b00);
  endtask
  task automatic step(input logic [2:0] c, input logic [17:0] a, input logic [15:0] d);
    go(c, a, d);
    fin;
  endtask
  task automatic look(input logic [17:0] a, input logic [15:0] exp);
    step(fpes_pkg::OP_READ, a, '0);
    chk(exp, s[31:16]);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // A hang is cut short well beyond the longest erase and its polling.
  always @(posedge clk)
  begin
    ticks++;
    if (ticks == 40000) err_count++;
    if (ticks == 40000) report_and_stop;
  end
  initial
  begin
    {rst_n, av_rd, av_wr, av_a, av_wd} = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    step(fpes_pkg::OP_PROG, 18'h00100, 16'h1234);
    chk(16'h0012, 16'(s[4:0]));
    look(18'h00100, 16'h1234);
    step(fpes_pkg::OP_PROG, 18'h3F000, 16'hABCD);
    step(fpes_pkg::OP_PROG, 18'h20000, 16'h5555);
    look(18'h3F000, 16'hABCD);
    $display("program test done");
    step(fpes_pkg::OP_PROG, 18'h00100, 16'hFFFF);
    chk(16'h0014, 16'(s[4:0]));
    look(18'h00100, 16'h1234);
    step(fpes_pkg::OP_RESET, '0, '0);
    chk(16'h0012, 16'(s[4:0]));
    go(fpes_pkg::OP_PROG, 18'h00300, 16'h0F0F);
    bus(fpes_pkg::REG_CTRL, 1'b1, 32'(fpes_pkg::OP_CHIP));
    fin;
    look(18'h20000, 16'h5555);
    $display("refusal test done");
    go(fpes_pkg::OP_SECT, 18'h00100, '0);
    repeat (80) @(posedge clk);
    bus(fpes_pkg::REG_ADDR, 1'b1, 32'h0003F000);
    bus(fpes_pkg::REG_CTRL, 1'b1, 32'(fpes_pkg::OP_ADD));
    fin;
    chk(16'h0012, 16'(s[4:0]));
    look(18'h00100, 16'hFFFF);
    look(18'h3F000, 16'hFFFF);
    look(18'h20000, 16'h5555);
    // An add asked for after the window has run out is refused and reported as late.
    go(fpes_pkg::OP_SECT, 18'h10000, '0);
    repeat (2060) @(posedge clk);
    bus(fpes_pkg::REG_ADDR, 1'b1, 32'h00020000);
    bus(fpes_pkg::REG_CTRL, 1'b1, 32'(fpes_pkg::OP_ADD));
    fin;
    chk(16'h001A, 16'(s[4:0]));
    look(18'h20000, 16'h5555);
    $display("sector erase test done");
    go(fpes_pkg::OP_PROG, 18'h00200, 16'h0000);
    repeat (60) @(posedge clk);
    bus(fpes_pkg::REG_CTRL, 1'b1, 32'h00000100);
    fin;
    chk(16'h0004, 16'(s[2:0]));
    bus(fpes_pkg::REG_CTRL, 1'b1, '0);
    $display("hardware reset test done");
    step(fpes_pkg::OP_CHIP, '0, '0);
    chk(16'h0012, 16'(s[4:0]));
    look(18'h20000, 16'hFFFF);
    bus(5'h10, 1'b0, '0);
    chk(16'h0000, s[15:0]);
    $display("chip erase test done");
    report_and_stop;
  end
endmodule
